// ---- vic_ctrl.sv ----
// Vectored fixed-priority interrupt controller with APB register access
//
// The register offsets and the APB interface to the registers were chosen for this implementation.
`timescale 1ns/1ps
// Overview of operation
// - A source event sets its request flag whether or not it is enabled.
// - A pending flag branches to its vector only when its enable is 1.
// - With the global enable at 0 no interrupt is taken.
// - Entry pushes the next instruction address, then loads the vector.
// - The return instruction pops the saved address from the stack.
// - Taking an interrupt clears the global enable automatically.
// - Requests arriving while blocked still set and hold their flags.
// - No request is acknowledged while the hardware stack is full.
// - Simultaneous requests are served lowest vector first, 04H highest, 38H lowest.
// - Vectors run 04H to 38H in steps of four, one per slot.
// - Any flag becoming set wakes the device; an already set flag does not.
// - Timer-2 register: compare A flag bit 5, compare P flag bit 4.
// - Timer-2 register: compare A enable bit 1, compare P enable bit 0.
// - Slot flags clear on service; timer-2 member flags stay set for software.
// - A member flag becoming set while its member enable is 1 sets its group flag, requesting the group vector.
// - Group service clears only the group flag, never the member flags.
// - Direct sources clear their own flag and the global enable on service.
module vic_ctrl (
   // Clock and reset
   input  wire  logic                  sys_clk,
   input  wire  logic                  rst,
   // APB register port
   input  wire  vic_pkg::vic_apb_req_t apb_req,
   output       vic_pkg::vic_apb_rsp_t apb_rsp,
   // Peripheral events, one-cycle pulses per slot
   input  wire  logic [13:0]           src_evt,
   input  wire  logic                  t2_cmpa_match_evt,
   input  wire  logic                  t2_cmpp_match_evt,
   // CPU fetch and stack side
   input  wire  vic_pkg::vic_cpu_req_t cpu_req,
   output       vic_pkg::vic_cpu_rsp_t cpu_rsp
);
   import vic_pkg::*;

   vic_state_t        st;
   vic_state_t        next_st;
   logic              wr_en;
   logic              rd_setup;
   logic              mapped;
   logic [13:0]       pend;
   logic              any_pend;
   logic [IDX_W-1:0]  sel_idx;
   logic              take;
   logic [13:0]       hw_set;
   logic              rise_a;
   logic              rise_p;

   default clocking cb @(posedge sys_clk); endclocking
   default disable iff (rst);

   // Lowest pending index has the highest priority
   function automatic logic [IDX_W-1:0] pick_idx(input logic [13:0] req);
      logic [IDX_W-1:0] r;
      r = '0;
      for (int i = NUM_SRC - 1; i >= 0; i--) begin
         if (req[i]) begin
            r = IDX_W'(i);
         end
      end
      return r;
   endfunction

   // Vector address of a slot: 04H for slot 0 up to 38H for slot 13
   function automatic logic [PC_W-1:0] vec_of(input logic [IDX_W-1:0] idx);
      return PC_W'({idx + 4'h1, 2'b00});
   endfunction

   function automatic logic is_mapped(input logic [ADDR_W-1:0] a);
      logic r;
      r = 1'b0;
      if (a == OFS_CTRL) begin
         r = 1'b1;
      end else if (a == OFS_FLAGS) begin
         r = 1'b1;
      end else if (a == OFS_ENABLES) begin
         r = 1'b1;
      end else if (a == OFS_T2) begin
         r = 1'b1;
      end else if (a == OFS_STATUS) begin
         r = 1'b1;
      end
      return r;
   endfunction

   assign wr_en    = apb_req.psel & apb_req.penable & apb_req.pwrite;
   assign rd_setup = apb_req.psel & ~apb_req.penable & ~apb_req.pwrite;
   assign mapped   = is_mapped(apb_req.paddr);
   assign pend     = st.flags & st.en;
   assign any_pend = |pend;
   assign sel_idx  = pick_idx(pend);
   assign take     = (st.fsm == ST_IDLE) & cpu_req.instr_boundary
                   & st.global_irq_enable & any_pend
                   & ~cpu_req.stack_full;

   always_comb begin
      vic_t2_t     t2_base;
      logic [13:0] fl_base;
      logic        gie_base;
      next_st  = st;
      t2_base  = st.t2;
      fl_base  = st.flags;
      gie_base = st.global_irq_enable;
      next_st.pop  = cpu_req.return_from_irq_instr;
      // Register writes
      if (wr_en && apb_req.paddr == OFS_CTRL) begin
         gie_base = apb_req.pwdata[CTRL_GIE_BIT];
      end else if (wr_en && apb_req.paddr == OFS_FLAGS) begin
         fl_base = apb_req.pwdata[13:0];
      end else if (wr_en && apb_req.paddr == OFS_ENABLES) begin
         next_st.en = apb_req.pwdata[13:0];
      end else if (wr_en && apb_req.paddr == OFS_T2) begin
         t2_base.t2_cmpa_match_flag = apb_req.pwdata[T2_CMPA_F_BIT];
         t2_base.t2_cmpp_match_flag = apb_req.pwdata[T2_CMPP_F_BIT];
         t2_base.t2_cmpa_match_en   = apb_req.pwdata[T2_CMPA_E_BIT];
         t2_base.t2_cmpp_match_en   = apb_req.pwdata[T2_CMPP_E_BIT];
      end
      // Member flags: set by event, never cleared by service
      next_st.t2 = t2_base;
      next_st.t2.t2_cmpa_match_flag = t2_base.t2_cmpa_match_flag | t2_cmpa_match_evt;
      next_st.t2.t2_cmpp_match_flag = t2_base.t2_cmpp_match_flag | t2_cmpp_match_evt;
      rise_a = next_st.t2.t2_cmpa_match_flag & ~st.t2.t2_cmpa_match_flag;
      rise_p = next_st.t2.t2_cmpp_match_flag & ~st.t2.t2_cmpp_match_flag;
      hw_set = src_evt;
      hw_set[SLOT_GROUP5] = src_evt[SLOT_GROUP5]
                          | (rise_a & next_st.t2.t2_cmpa_match_en)
                          | (rise_p & next_st.t2.t2_cmpp_match_en);
      // Interrupt entry
      if (take) begin
         fl_base[sel_idx]  = 1'b0;
         gie_base          = 1'b0;
         next_st.idx       = sel_idx;
         next_st.push_pc   = cpu_req.next_pc;
         next_st.vector    = vec_of(sel_idx);
         next_st.fsm       = ST_PUSH;
      end else if (st.fsm == ST_PUSH) begin
         next_st.fsm = ST_LOAD;
      end else if (st.fsm == ST_LOAD) begin
         next_st.fsm = ST_IDLE;
      end
      // Set wins over any clear in the same cycle
      next_st.flags = fl_base | hw_set;
      next_st.global_irq_enable = gie_base;
      next_st.wake = (|(next_st.flags & ~st.flags)) | rise_a | rise_p;
      // Read data captured in the setup phase
      if (rd_setup) begin
         next_st.prdata = '0;
         if (apb_req.paddr == OFS_CTRL) begin
            next_st.prdata[CTRL_GIE_BIT] = st.global_irq_enable;
         end else if (apb_req.paddr == OFS_FLAGS) begin
            next_st.prdata[13:0] = st.flags;
         end else if (apb_req.paddr == OFS_ENABLES) begin
            next_st.prdata[13:0] = st.en;
         end else if (apb_req.paddr == OFS_T2) begin
            next_st.prdata[T2_CMPA_F_BIT] = st.t2.t2_cmpa_match_flag;
            next_st.prdata[T2_CMPP_F_BIT] = st.t2.t2_cmpp_match_flag;
            next_st.prdata[T2_CMPA_E_BIT] = st.t2.t2_cmpa_match_en;
            next_st.prdata[T2_CMPP_E_BIT] = st.t2.t2_cmpp_match_en;
         end else if (apb_req.paddr == OFS_STATUS) begin
            next_st.prdata[STAT_FSM_LSB +: 2]     = st.fsm;
            next_st.prdata[STAT_IDX_LSB +: IDX_W] = st.idx;
            next_st.prdata[STAT_PEND_BIT]         = any_pend;
         end
      end
   end

   always_ff @(posedge sys_clk or posedge rst) begin
      if (rst) begin
         st                   <= '0;
         st.fsm               <= ST_IDLE;
         st.global_irq_enable <= GIE_RST;
         st.flags             <= FLAGS_RST;
         st.en                <= EN_RST;
      end else begin
         st <= next_st;
      end
   end

   // Outputs
   assign apb_rsp.prdata      = st.prdata;
   assign apb_rsp.pready      = 1'b1;
   assign apb_rsp.pslverr     = apb_req.psel & apb_req.penable & ~mapped;
   assign cpu_rsp.busy        = (st.fsm != ST_IDLE);
   assign cpu_rsp.stack_push  = (st.fsm == ST_PUSH);
   assign cpu_rsp.push_pc     = st.push_pc;
   assign cpu_rsp.pc_load     = (st.fsm == ST_LOAD);
   assign cpu_rsp.vector_addr = st.vector;
   assign cpu_rsp.stack_pop   = st.pop;
   assign cpu_rsp.wake        = st.wake;

   // Assertions
   sequence s_entry;
      st.fsm == ST_IDLE ##1 st.fsm == ST_PUSH;
   endsequence

   a_src_flag_set: assert property (src_evt[0] |=> st.flags[0])
      else $error("source event did not set its flag");
   a_enable_gates: assert property (s_entry |-> (($past(pend) >> st.idx) & 14'h1) != 14'h0)
      else $error("entry taken for a disabled slot");
   a_gie_blocks: assert property (!st.global_irq_enable |=> st.fsm != ST_PUSH)
      else $error("entry taken with global enable off");
   a_entry_seq: assert property (st.fsm == ST_PUSH |=> st.fsm == ST_LOAD ##1 st.fsm == ST_IDLE)
      else $error("push not followed by vector load");
   a_return_pop: assert property (cpu_req.return_from_irq_instr |=> cpu_rsp.stack_pop)
      else $error("return did not pop the stack");
   a_gie_cleared: assert property (st.fsm == ST_PUSH |-> !st.global_irq_enable)
      else $error("global enable not cleared on entry");
   a_flag_held: assert property (st.flags[3] && !wr_en && !take |=> st.flags[3])
      else $error("pending flag lost while blocked");
   a_stack_full: assert property (cpu_req.stack_full |=> st.fsm != ST_PUSH)
      else $error("entry taken with stack full");
   a_priority: assert property (s_entry |-> ($past(pend) & ((14'h1 << st.idx) - 14'h1)) == 14'h0)
      else $error("higher priority request skipped");
   a_last_vector: assert property (cpu_rsp.pc_load && st.idx == SLOT_GROUP5 |-> cpu_rsp.vector_addr == 13'h0038)
      else $error("lowest slot vector wrong");
   a_wake_rise: assert property (src_evt[4] && !st.flags[4] |=> cpu_rsp.wake)
      else $error("new flag did not wake");
   a_member_kept: assert property (st.fsm == ST_PUSH && st.t2.t2_cmpa_match_flag && !wr_en
                                   |=> st.t2.t2_cmpa_match_flag)
      else $error("member flag cleared by service");
   a_auto_clear: assert property (s_entry |-> !st.flags[st.idx]
                                  || (($past(hw_set) >> st.idx) & 14'h1) != 14'h0
                                  || $past(wr_en))
      else $error("serviced slot flag not cleared");

   c_group5_entry: cover property (s_entry ##0 st.idx == SLOT_GROUP5);
   c_blocked_full: cover property (any_pend && st.global_irq_enable && cpu_req.stack_full);
   c_back_to_back: cover property (st.fsm == ST_LOAD ##1 st.fsm == ST_IDLE ##1 st.fsm == ST_PUSH);
   c_wake: cover property (cpu_rsp.wake);

endmodule // vic_ctrl

// ---- vic_pkg.sv ----
// Package for the vectored interrupt controller: constants, register map and carrier types
package vic_pkg;
   localparam int         NUM_SRC        = 14;
   localparam int         PC_W           = 13;
   localparam int         ADDR_W         = 8;
   localparam int         IDX_W          = 4;
   // Slot indices (vector = 4 * (index + 1))
   localparam logic [3:0] SLOT_GROUP5    = 4'hd;
   // Register byte offsets
   localparam logic [7:0] OFS_CTRL       = 8'h00;
   localparam logic [7:0] OFS_FLAGS      = 8'h04;
   localparam logic [7:0] OFS_ENABLES    = 8'h08;
   localparam logic [7:0] OFS_T2         = 8'h0c;
   localparam logic [7:0] OFS_STATUS     = 8'h10;
   // Field positions
   localparam int         CTRL_GIE_BIT   = 0;
   localparam int         T2_CMPA_F_BIT  = 5;
   localparam int         T2_CMPP_F_BIT  = 4;
   localparam int         T2_CMPA_E_BIT  = 1;
   localparam int         T2_CMPP_E_BIT  = 0;
   localparam int         STAT_FSM_LSB   = 0;
   localparam int         STAT_IDX_LSB   = 4;
   localparam int         STAT_PEND_BIT  = 8;
   // Reset values
   localparam logic [13:0] FLAGS_RST     = 14'h0000;
   localparam logic [13:0] EN_RST        = 14'h0000;
   localparam logic        GIE_RST       = 1'b0;

   typedef enum logic [1:0] {
      ST_IDLE = 2'b00,
      ST_PUSH = 2'b01,
      ST_LOAD = 2'b10
   } vic_fsm_t;

   typedef struct packed {
      logic t2_cmpa_match_flag;
      logic t2_cmpp_match_flag;
      logic t2_cmpa_match_en;
      logic t2_cmpp_match_en;
   } vic_t2_t;

   typedef struct packed {
      logic              psel;
      logic              penable;
      logic              pwrite;
      logic [ADDR_W-1:0] paddr;
      logic [31:0]       pwdata;
   } vic_apb_req_t;

   typedef struct packed {
      logic [31:0] prdata;
      logic        pready;
      logic        pslverr;
   } vic_apb_rsp_t;

   typedef struct packed {
      logic            instr_boundary;
      logic            return_from_irq_instr;
      logic            stack_full;
      logic [PC_W-1:0] next_pc;
   } vic_cpu_req_t;

   typedef struct packed {
      logic            busy;
      logic            stack_push;
      logic [PC_W-1:0] push_pc;
      logic            pc_load;
      logic [PC_W-1:0] vector_addr;
      logic            stack_pop;
      logic            wake;
   } vic_cpu_rsp_t;

   typedef struct packed {
      vic_fsm_t           fsm;
      logic               global_irq_enable;
      logic [13:0]        flags;
      logic [13:0]        en;
      vic_t2_t            t2;
      logic [IDX_W-1:0]   idx;
      logic [PC_W-1:0]    push_pc;
      logic [PC_W-1:0]    vector;
      logic               pop;
      logic               wake;
      logic [31:0]        prdata;
   } vic_state_t;
endpackage

// ---- vic_cpu_model.sv ----
// Behavioural CPU program counter and hardware stack facing the interrupt controller
`timescale 1ns/1ps
module vic_cpu_model #(parameter int DEPTH = 2) (
   // Clock, reset and return request
   input  wire logic                  sys_clk,
   input  wire logic                  rst,
   input  wire logic                  ret,
   // Controller side
   input  wire vic_pkg::vic_cpu_rsp_t cpu_rsp,
   output      vic_pkg::vic_cpu_req_t cpu_req,
   output      logic [12:0]           pc
);
   import vic_pkg::*;
   logic [PC_W-1:0] stk [DEPTH];
   int              sp;
   logic            tick;
   // Boundary every other cycle; a full stack withholds entries
   assign cpu_req = '{tick, ret, (sp == DEPTH), pc + 13'h1};
   always_ff @(posedge sys_clk or posedge rst) begin
      if (rst) begin
         pc <= 13'h100;
         sp <= 0;
         tick <= 1'b0;
      end else begin
         tick <= ~tick;
         if (cpu_rsp.stack_push && sp < DEPTH) begin
            stk[sp] <= cpu_rsp.push_pc;
            sp <= sp + 1;
         end
         if (cpu_rsp.pc_load) pc <= cpu_rsp.vector_addr;
         if (cpu_rsp.stack_pop && sp > 0) begin
            pc <= stk[sp - 1];
            sp <= sp - 1;
         end
      end
   end
endmodule // vic_cpu_model

// ---- tb_vectored_interrupt_controller.sv ----
// Self-checking testbench for the vectored interrupt controller
`timescale 1ns/1ps
module tb_vectored_interrupt_controller;
   import vic_pkg::*;
   logic         sys_clk, rst, ret, t2a, t2p, err;
   logic [13:0]  src_evt, rem, m;
   logic [12:0]  pc, ret_pc;
   logic [31:0]  rd;
   logic [12:0]  exp_q[$];
   logic [7:0]   regs [4] = '{OFS_CTRL, OFS_FLAGS, OFS_ENABLES, OFS_T2};
   vic_apb_req_t apb_req;
   vic_apb_rsp_t apb_rsp;
   vic_cpu_req_t cpu_req;
   vic_cpu_rsp_t cpu_rsp;
   int           fail_count = 0;
   int           samples_checked = 0;
   int           wakes = 0;
   vic_ctrl DUT (.sys_clk(sys_clk), .rst(rst), .apb_req(apb_req), .apb_rsp(apb_rsp), .src_evt(src_evt),
      .t2_cmpa_match_evt(t2a), .t2_cmpp_match_evt(t2p), .cpu_req(cpu_req), .cpu_rsp(cpu_rsp));
   vic_cpu_model #(.DEPTH(2)) cpu (.sys_clk(sys_clk), .rst(rst), .ret(ret), .cpu_rsp(cpu_rsp),
      .cpu_req(cpu_req), .pc(pc));
   task automatic chk(input string name, input logic [31:0] exp, input logic [31:0] got);
      samples_checked++;
      if (got !== exp) begin
         fail_count++;
         $display("ERROR %s expected %h seen %h", name, exp, got);
      end
   endtask
   task automatic complete_run();
      $display("Checks %0d mismatches %0d", samples_checked, fail_count);
      if (fail_count == 0 && samples_checked > 0) $display("All tests passed");
      else $display("Some tests failed");
      $finish;
   endtask
   task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
      @(posedge sys_clk);
      apb_req <= '{1'b1, 1'b0, w, a, d};
      @(posedge sys_clk);
      apb_req.penable <= 1'b1;
      do @(posedge sys_clk); while (apb_rsp.pready !== 1'b1);
      rd = apb_rsp.prdata;
      err = apb_rsp.pslverr;
      apb_req.psel <= 1'b0;
      apb_req.penable <= 1'b0;
   endtask
   task automatic rdc(input logic [7:0] a, input logic [31:0] e, input string name);
      apb(1'b0, a, 32'h0);
      chk(name, e, rd);
   endtask
   task automatic pulse(input logic [13:0] s, input logic a, input logic p);
      @(posedge sys_clk);
      src_evt <= s;
      t2a <= a;
      t2p <= p;
      @(posedge sys_clk);
      src_evt <= '0;
      t2a <= 1'b0;
      t2p <= 1'b0;
   endtask
   // Note the vector, re-enable, wait for the entry to finish
   task automatic take(input logic [12:0] v);
      int n;
      n = 0;
      exp_q.push_back(v);
      ret_pc = pc + 13'h1;
      apb(1'b1, OFS_CTRL, 32'h1);
      while ((exp_q.size() != 0 || cpu_rsp.busy !== 1'b0) && n < 40) begin
         @(negedge sys_clk);
         n++;
      end
      chk("entry done", 32'h0, (n == 40) ? 32'h1 : 32'h0);
   endtask
   task automatic do_ret();
      @(posedge sys_clk);
      ret <= 1'b1;
      @(posedge sys_clk);
      ret <= 1'b0;
      repeat (3) @(posedge sys_clk);
   endtask
   // Result watcher: every vector load takes the oldest note
   always @(negedge sys_clk) begin
      if (cpu_rsp.wake === 1'b1) wakes++;
      if (cpu_rsp.pc_load === 1'b1) begin
         if (exp_q.size() == 0) chk("unexpected entry", 32'h0, {19'h0, cpu_rsp.vector_addr});
         else chk("vector", {19'h0, exp_q.pop_front()}, {19'h0, cpu_rsp.vector_addr});
      end
   end
   initial begin
      sys_clk = 1'b0;
      forever #4 sys_clk = ~sys_clk;
   end
   initial begin
      repeat (20000) @(posedge sys_clk);
      fail_count++;
      $display("ERROR watchdog expected finish seen timeout");
      complete_run();
   end
   initial begin
      rst = 1'b1;
      ret = 1'b0;
      t2a = 1'b0;
      t2p = 1'b0;
      src_evt = '0;
      apb_req = '0;
      void'($urandom(9));
      repeat (2) @(posedge sys_clk);
      rst <= 1'b0;
      foreach (regs[i]) rdc(regs[i], 32'h0, "reset value");
      apb(1'b1, OFS_T2, 32'hff);
      rdc(OFS_T2, 32'h33, "t2 layout");
      apb(1'b1, OFS_T2, 32'h0);
      // The timer-2 write set the group flag and woke the device; start clean
      apb(1'b1, OFS_FLAGS, 32'h0);
      apb(1'b0, 8'h14, 32'h0);
      chk("unmapped error", 32'h1, {31'h0, err});
      wakes = 0;
      $display("Test registers done");
      m = 14'($urandom) | 14'h1;
      pulse(m, 1'b0, 1'b0);
      rdc(OFS_FLAGS, {18'h0, m}, "flags set");
      pulse(m, 1'b0, 1'b0);
      apb(1'b1, OFS_ENABLES, 32'h3fff);
      repeat (10) @(posedge sys_clk);
      rdc(OFS_FLAGS, {18'h0, m}, "flags held");
      chk("wake count", 32'h1, wakes);
      $display("Test blocked requests done");
      apb(1'b1, OFS_ENABLES, 32'h3fdf);
      apb(1'b1, OFS_FLAGS, 32'h3fff);
      rem = 14'h3fff;
      for (int k = 0; k < 14; k++) begin
         if (k != 5) begin
            take(13'(4 * (k + 1)));
            rem[k] = 1'b0;
            rdc(OFS_CTRL, 32'h0, "enable after entry");
            rdc(OFS_FLAGS, {18'h0, rem}, "flags after entry");
            do_ret();
            chk("return pc", {19'h0, ret_pc}, {19'h0, pc});
         end
      end
      apb(1'b1, OFS_CTRL, 32'h1);
      repeat (10) @(posedge sys_clk);
      rdc(OFS_CTRL, 32'h1, "disabled not taken");
      apb(1'b1, OFS_CTRL, 32'h0);
      apb(1'b1, OFS_FLAGS, 32'h0);
      $display("Test priority done");
      apb(1'b1, OFS_T2, 32'h03);
      apb(1'b1, OFS_ENABLES, 32'h2000);
      pulse(14'h0, 1'b1, 1'b1);
      rdc(OFS_T2, 32'h33, "t2 flags");
      rdc(OFS_FLAGS, 32'h2000, "group flag");
      take(13'h38);
      rdc(OFS_T2, 32'h33, "member flags kept");
      rdc(OFS_FLAGS, 32'h0, "group flag cleared");
      do_ret();
      $display("Test group done");
      apb(1'b1, OFS_ENABLES, 32'h3);
      apb(1'b1, OFS_FLAGS, 32'h3);
      take(13'h04);
      take(13'h08);
      apb(1'b1, OFS_FLAGS, 32'h1);
      apb(1'b1, OFS_CTRL, 32'h1);
      repeat (10) @(posedge sys_clk);
      rdc(OFS_CTRL, 32'h1, "stack full holds");
      // The pop frees a slot, so the held request enters on its own
      exp_q.push_back(13'h04);
      do_ret();
      repeat (4) @(posedge sys_clk);
      chk("entry after pop", 32'h0, exp_q.size());
      rdc(OFS_FLAGS, 32'h0, "flags after full");
      $display("Test stack full done");
      complete_run();
   end
endmodule // tb_vectored_interrupt_controller
